// [pkg/brake_cur_pkg.sv]
package brake_cur_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 40_000_000;   // core_clk rate
  localparam int DELAY_UNIT_US = 1000;         // brake delays count milliseconds
  localparam int CYC_PER_UNIT  = CLK_HZ / 1_000_000 * DELAY_UNIT_US;
  localparam int PWM_PCT_FULL  = 100;          // duty figure meaning always high
  localparam int CYC_PER_PCT   = CLK_HZ / PWM_PCT_FULL;

  // ----------------------------------------------------------------
  // object dictionary map
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_BRAKE    = 16'h2038;
  localparam logic [15:0] IDX_CURRENTS = 16'h2039;

  localparam logic [7:0] SUB_COUNT     = 8'h00;
  localparam logic [7:0] SUB_CLOSE_DLY = 8'h01;  // standstill to brake closed
  localparam logic [7:0] SUB_OFF_DLY   = 8'h02;  // brake closed to current off
  localparam logic [7:0] SUB_OPEN_DLY  = 8'h03;  // current on to brake open
  localparam logic [7:0] SUB_RUN_DLY   = 8'h04;  // brake open to operation enabled
  localparam logic [7:0] SUB_PWM_FREQ  = 8'h05;
  localparam logic [7:0] SUB_PWM_DUTY  = 8'h06;

  localparam logic [7:0] SUB_FIELD     = 8'h01;
  localparam logic [7:0] SUB_TORQUE    = 8'h02;
  localparam logic [7:0] SUB_ALPHA     = 8'h03;
  localparam logic [7:0] SUB_BETA      = 8'h04;
  localparam logic [7:0] SUB_TOTAL     = 8'h05;

  localparam logic [7:0]  BRAKE_ENTRY_COUNT   = 8'h06;
  localparam logic [7:0]  CURRENT_ENTRY_COUNT = 8'h05;
  localparam logic [31:0] BRAKE_RST           = 32'h0000_0000;
  localparam logic [31:0] READING_RST         = 32'h0000_0000;
  localparam logic [31:0] DUTY_MIN            = 32'h0000_0002;
  localparam logic [31:0] DUTY_MAX            = 32'h0000_0064;

  // 1/sqrt(3) in q16 for the clarke beta term
  localparam logic [16:0] INV_SQRT3_Q16 = 17'h093CD;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] index;
    logic [7:0]  subindex;
    logic [31:0] wdata;
  } od_req_t;

  typedef struct packed {
    logic        ack;
    logic        abort;
    logic [31:0] rdata;
  } od_rsp_t;

  typedef struct packed {
    logic        valid;
    logic        closed_loop;
    logic [31:0] phase_a;
    logic [31:0] phase_b;
    logic [31:0] field;
    logic [31:0] torque;
  } meas_t;

endpackage : brake_cur_pkg

// [core/root_extract.sv]
// bit-serial square root; one result bit per clock, busy while working
module root_extract
  import brake_cur_pkg::*;
#(
  parameter int W = 64
) (
  input  wire logic           core_clk,
  input  wire logic           nrst,
  input  wire logic           start,
  input  wire logic [W-1:0]   radicand,
  output logic                busy_ff,
  output logic                done_ff,
  output logic [W/2-1:0]      root_ff
);

  logic [W-1:0] rem_ff;
  logic [W-1:0] res_ff;
  logic [W-1:0] bit_ff;
  logic [W-1:0] trial;

  assign trial = res_ff + bit_ff;

  // ----------------------------------------------------------------
  // restoring iteration, two radicand bits per step
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rem_ff  <= '0;
      res_ff  <= '0;
      bit_ff  <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      root_ff <= '0;
    end else begin
      done_ff <= 1'b0;
      if (start && !busy_ff) begin
        rem_ff  <= radicand;
        res_ff  <= '0;
        bit_ff  <= {2'b01, {(W-2){1'b0}}};
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        if (rem_ff >= trial) begin
          rem_ff <= rem_ff - trial;
          res_ff <= (res_ff >> 1) + bit_ff;
        end else begin
          res_ff <= res_ff >> 1;
        end
        bit_ff <= bit_ff >> 2;
        if (bit_ff[0]) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
          root_ff <= (W/2)'((rem_ff >= trial) ? ((res_ff >> 1) + bit_ff) : (res_ff >> 1));
        end
      end
    end
  end

endmodule : root_extract

// [core/brake_pwm.sv]
// brake drive chopper; phase accumulator so any hertz figure below the clock rate works without a divider
module brake_pwm
  import brake_cur_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        release_req,
  input  wire logic [31:0] freq_hz,
  input  wire logic [31:0] duty_pct,
  output logic             drive_ff
);

  localparam logic [31:0] WRAP = 32'(CLK_HZ);

  logic [31:0] acc_ff;
  logic [31:0] nxt_acc;
  logic [31:0] high_lim;
  logic        chop;

  // zero or out-of-range figures mean steady drive rather than no drive
  assign chop     = (freq_hz != '0) && (freq_hz < WRAP) && (duty_pct != '0)
                    && (duty_pct < 32'(PWM_PCT_FULL));
  assign high_lim = 32'(duty_pct[6:0] * CYC_PER_PCT);
  assign nxt_acc  = (acc_ff + freq_hz >= WRAP) ? acc_ff + freq_hz - WRAP
                                               : acc_ff + freq_hz;

  // ----------------------------------------------------------------
  // period phase: advances freq_hz per cycle, wraps at the clock rate
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      acc_ff <= '0;
    end else begin
      acc_ff <= (release_req && chop) ? nxt_acc : '0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      drive_ff <= 1'b0;
    end else begin
      drive_ff <= release_req && (!chop || acc_ff < high_lim);
    end
  end

  chk_pwm_off_closed : assert property (@(posedge core_clk) disable iff (!nrst)
    !release_req |=> !drive_ff) else $error("brake drive active while closed");

endmodule : brake_pwm

// [core/brake_current_unit.sv]
//
// Contract
// - On stopping, the brake closes only after the first delay from standstill.
// - After the brake closes, the motor current goes off after the second delay.
// - On enabling, current goes on first and the brake opens after the third delay.
// - After the brake opens, operation enabled follows after the fourth delay.
// - The fifth brake entry sets the brake PWM frequency in hertz.
// - The sixth brake entry sets the brake PWM high time in percent of the period.
// - All currents except the fifth entry are reported in milliamperes as peak values.
// - The first current entry is the signed 32-bit field-forming current.
// - The second current entry is the signed 32-bit torque-forming current.
// - The third and fourth entries are the Clarke alpha and beta currents.
// - The fifth entry is sqrt(alpha^2 + beta^2) divided by sqrt(2).
// - In closed loop the total takes the torque sign, else it stays non-negative.
// - Field and torque entries read zero unless closed loop is active.
// - The five current entries are read-only and may feed transmit process objects.
//
module brake_current_unit
  import brake_cur_pkg::*;
#(
  parameter int UNIT_CYCLES = CYC_PER_UNIT
) (
  input  wire logic    core_clk,
  input  wire logic    nrst,
  input  wire od_req_t od_req,
  output od_rsp_t      od_rsp_ff,
  input  wire logic    enable_req,
  input  wire logic    standstill,
  input  wire meas_t   meas,
  output logic         motor_current_on_ff,
  output logic         brake_open_ff,
  output logic         brake_drive_ff,
  output logic         op_enabled_ff,
  output logic         readings_fresh_ff
);

  typedef enum logic [2:0] {
    ST_OFF       = 3'b000,
    ST_OPEN_WAIT = 3'b001,
    ST_RUN_WAIT  = 3'b010,
    ST_ENABLED   = 3'b011,
    ST_STILL     = 3'b100,
    ST_OFF_WAIT  = 3'b101
  } seq_t;

  seq_t        state_ff;
  seq_t        nxt_state;
  logic [31:0] dly_ff [4];
  logic [31:0] freq_ff;
  logic [31:0] duty_ff;
  logic [31:0] pre_ff;
  logic [31:0] elapsed_ff;
  logic [31:0] cur_dly;
  logic        dly_done;

  // ----------------------------------------------------------------
  // object dictionary decode
  // ----------------------------------------------------------------
  function automatic logic duty_ok(input logic [31:0] v);
    return (v == '0) || (v >= DUTY_MIN && v <= DUTY_MAX);
  endfunction : duty_ok

  logic wr_brake;
  logic wr_cur;
  logic wr_dly_hit;
  logic wr_ok;

  assign wr_brake   = od_req.valid && od_req.write && od_req.index == IDX_BRAKE;
  assign wr_cur     = od_req.valid && od_req.write && od_req.index == IDX_CURRENTS;
  assign wr_dly_hit = od_req.subindex >= SUB_CLOSE_DLY && od_req.subindex <= SUB_RUN_DLY;
  assign wr_ok      = wr_brake && (wr_dly_hit || od_req.subindex == SUB_PWM_FREQ
                      || (od_req.subindex == SUB_PWM_DUTY && duty_ok(od_req.wdata)));

  // ----------------------------------------------------------------
  // brake settings storage
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        dly_ff[i] <= BRAKE_RST;
      end
      freq_ff <= BRAKE_RST;
      duty_ff <= BRAKE_RST;
    end else if (wr_ok) begin
      if (wr_dly_hit) begin
        dly_ff[2'(od_req.subindex - SUB_CLOSE_DLY)] <= od_req.wdata;
      end else if (od_req.subindex == SUB_PWM_FREQ) begin
        freq_ff <= od_req.wdata;
      end else begin
        duty_ff <= od_req.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // delay timer: unit prescaler plus elapsed units, cleared on state change
  // ----------------------------------------------------------------
  always_comb begin
    unique case (state_ff)
      ST_STILL:     cur_dly = dly_ff[0];
      ST_OFF_WAIT:  cur_dly = dly_ff[1];
      ST_OPEN_WAIT: cur_dly = dly_ff[2];
      ST_RUN_WAIT:  cur_dly = dly_ff[3];
      default:      cur_dly = '0;
    endcase
  end

  assign dly_done = elapsed_ff >= cur_dly;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pre_ff     <= '0;
      elapsed_ff <= '0;
    end else if (nxt_state != state_ff || (state_ff == ST_STILL && !standstill)) begin
      pre_ff     <= '0;
      elapsed_ff <= '0;
    end else if (pre_ff == 32'(UNIT_CYCLES - 1)) begin
      pre_ff     <= '0;
      elapsed_ff <= dly_done ? elapsed_ff : elapsed_ff + 32'h1;
    end else begin
      pre_ff <= pre_ff + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // brake sequencer; dropping the request mid-enable reverses it, a new request while stopping waits for ST_OFF
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_OFF:       if (enable_req) nxt_state = ST_OPEN_WAIT;
      ST_OPEN_WAIT: if (!enable_req) nxt_state = ST_OFF_WAIT;
                    else if (dly_done) nxt_state = ST_RUN_WAIT;
      ST_RUN_WAIT:  if (!enable_req) nxt_state = ST_STILL;
                    else if (dly_done) nxt_state = ST_ENABLED;
      ST_ENABLED:   if (!enable_req) nxt_state = ST_STILL;
      ST_STILL:     if (standstill && dly_done) nxt_state = ST_OFF_WAIT;
      ST_OFF_WAIT:  if (dly_done) nxt_state = ST_OFF;
      default:      nxt_state = ST_OFF;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs follow the next state so they change on the same edge as it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      motor_current_on_ff <= 1'b0;
      brake_open_ff       <= 1'b0;
      op_enabled_ff       <= 1'b0;
    end else begin
      motor_current_on_ff <= nxt_state != ST_OFF;
      brake_open_ff       <= nxt_state inside {ST_RUN_WAIT, ST_ENABLED, ST_STILL};
      op_enabled_ff       <= nxt_state == ST_ENABLED;
    end
  end

  brake_pwm u_pwm (
    .core_clk    (core_clk),
    .nrst        (nrst),
    .release_req (brake_open_ff),
    .freq_hz     (freq_ff),
    .duty_pct    (duty_ff),
    .drive_ff    (brake_drive_ff)
  );

  // ----------------------------------------------------------------
  // current readings: clarke stage, then square root of half the power sum
  // ----------------------------------------------------------------
  logic [31:0]        field_ff;
  logic [31:0]        torque_ff;
  logic signed [31:0] alpha_ff;
  logic signed [31:0] beta_ff;
  logic [31:0]        total_ff;
  logic               sign_neg_ff;
  logic               closed_ff;
  logic               stage_ff;
  logic               root_busy;
  logic               root_done;
  logic [31:0]        root_val;
  logic signed [33:0] beta_sum;
  logic signed [51:0] beta_prod;
  logic [63:0]        alpha_sq;
  logic [63:0]        beta_sq;
  logic [64:0]        power_sum;
  logic               take_meas;

  assign take_meas = meas.valid && !stage_ff && !root_busy;
  assign beta_sum  = 34'(signed'(meas.phase_a)) + 34'(signed'({meas.phase_b, 1'b0}));
  assign beta_prod = 52'(beta_sum) * 52'(signed'({1'b0, INV_SQRT3_Q16}));
  assign alpha_sq  = 64'(alpha_ff) * 64'(alpha_ff);
  assign beta_sq   = 64'(beta_ff) * 64'(beta_ff);
  assign power_sum = {1'b0, alpha_sq} + {1'b0, beta_sq};

  // measurements arriving while a root is in flight are dropped, not queued
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      field_ff    <= READING_RST;
      torque_ff   <= READING_RST;
      alpha_ff    <= '0;
      beta_ff     <= '0;
      sign_neg_ff <= 1'b0;
      closed_ff   <= 1'b0;
    end else if (take_meas) begin
      field_ff    <= meas.closed_loop ? meas.field : '0;
      torque_ff   <= meas.closed_loop ? meas.torque : '0;
      alpha_ff    <= signed'(meas.phase_a);
      beta_ff     <= 32'(beta_prod >>> 16);
      sign_neg_ff <= meas.closed_loop && meas.torque[31];
      closed_ff   <= meas.closed_loop;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stage_ff <= 1'b0;
    end else begin
      stage_ff <= take_meas;
    end
  end

  root_extract #(.W(64)) u_root (
    .core_clk (core_clk),
    .nrst     (nrst),
    .start    (stage_ff),
    .radicand (power_sum[64:1]),
    .busy_ff  (root_busy),
    .done_ff  (root_done),
    .root_ff  (root_val)
  );

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      total_ff          <= READING_RST;
      readings_fresh_ff <= 1'b0;
    end else begin
      readings_fresh_ff <= root_done;
      if (root_done) begin
        total_ff <= sign_neg_ff ? 32'(-signed'(root_val)) : root_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux and answer; one answer per request, one cycle later
  // ----------------------------------------------------------------
  logic [31:0] rd_val;
  logic        rd_hit;

  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    if (od_req.index == IDX_BRAKE) begin
      unique case (od_req.subindex)
        SUB_COUNT:     rd_val = {24'h0, BRAKE_ENTRY_COUNT};
        SUB_CLOSE_DLY: rd_val = dly_ff[0];
        SUB_OFF_DLY:   rd_val = dly_ff[1];
        SUB_OPEN_DLY:  rd_val = dly_ff[2];
        SUB_RUN_DLY:   rd_val = dly_ff[3];
        SUB_PWM_FREQ:  rd_val = freq_ff;
        SUB_PWM_DUTY:  rd_val = duty_ff;
        default:       rd_hit = 1'b0;
      endcase
    end else if (od_req.index == IDX_CURRENTS) begin
      unique case (od_req.subindex)
        SUB_COUNT:  rd_val = {24'h0, CURRENT_ENTRY_COUNT};
        SUB_FIELD:  rd_val = field_ff;
        SUB_TORQUE: rd_val = torque_ff;
        SUB_ALPHA:  rd_val = alpha_ff;
        SUB_BETA:   rd_val = beta_ff;
        SUB_TOTAL:  rd_val = total_ff;
        default:    rd_hit = 1'b0;
      endcase
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      od_rsp_ff <= '0;
    end else begin
      od_rsp_ff.ack   <= od_req.valid;
      od_rsp_ff.abort <= od_req.valid && (od_req.write ? !wr_ok : !rd_hit);
      od_rsp_ff.rdata <= (od_req.valid && !od_req.write) ? rd_val : '0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_brake_needs_current : assert property (@(posedge core_clk) disable iff (!nrst)
    brake_open_ff |-> motor_current_on_ff) else $error("brake open without current");

  chk_enabled_needs_open : assert property (@(posedge core_clk) disable iff (!nrst)
    op_enabled_ff |-> brake_open_ff) else $error("enabled with brake closed");

  chk_close_after_still : assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(brake_open_ff) |-> $past(standstill) && $past(dly_done))
    else $error("brake closed early");

  chk_off_after_close : assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(motor_current_on_ff) |-> !brake_open_ff && $past(dly_done))
    else $error("current off before brake delay");

  chk_open_after_delay : assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(brake_open_ff) |-> $past(motor_current_on_ff, 1) && $past(dly_done))
    else $error("brake opened early");

  chk_dq_zero_open : assert property (@(posedge core_clk) disable iff (!nrst)
    !closed_ff |-> field_ff == '0 && torque_ff == '0)
    else $error("field or torque shown in open loop");

  chk_total_sign : assert property (@(posedge core_clk) disable iff (!nrst)
    root_done && !sign_neg_ff |=> !total_ff[31]) else $error("total negative");

  chk_ro_reject : assert property (@(posedge core_clk) disable iff (!nrst)
    wr_cur |=> od_rsp_ff.ack && od_rsp_ff.abort && ($stable(total_ff) || $past(root_done)))
    else $error("current write accepted");

  chk_duty_range : assert property (@(posedge core_clk) disable iff (!nrst)
    duty_ff == '0 || (duty_ff >= DUTY_MIN && duty_ff <= DUTY_MAX))
    else $error("duty out of range");

endmodule : brake_current_unit

// [bench/od_master.sv]
// dictionary master: one request at a time, held until the edge that takes it
module od_master
  import brake_cur_pkg::*;
(
  input  wire logic    core_clk,
  output od_req_t      od_req,
  input  wire od_rsp_t od_rsp_ff,
  output logic         lost
);
  timeunit 1ns;
  timeprecision 100ps;

  initial od_req = '0;
  initial lost = 1'b0;

  // request stands one cycle; the answer pulse is looked at in its own cycle
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                      input logic [31:0] wd, output logic [31:0] rd, output logic ab);
    int n;
    n = 0;
    @(posedge core_clk);
    od_req <= '{1'b1, wr, idx, sub, wd};
    @(posedge core_clk);
    od_req <= '0;
    #1;
    while (od_rsp_ff.ack !== 1'b1 && n < 4) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    lost = (n == 4);
    rd = od_rsp_ff.rdata;
    ab = od_rsp_ff.abort;
  endtask : xfer
endmodule : od_master

// [bench/brake_current_unit_tb.sv]
module brake_current_unit_tb
  import brake_cur_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int U = 4;   // short delay unit keeps the run brief
  logic        core_clk, nrst, enable_req, standstill;
  od_req_t     od_req;
  od_rsp_t     od_rsp_ff;
  meas_t       meas;
  logic        cur_on, brk_open, brk_drv, op_en, fresh, lost, ab, prv;
  logic [31:0] d, last_tot;
  int          fail_count, checks, n, hi, rises;
  int          dl [4];

  brake_current_unit #(.UNIT_CYCLES(U)) dut (
    .core_clk(core_clk), .nrst(nrst), .od_req(od_req), .od_rsp_ff(od_rsp_ff),
    .enable_req(enable_req), .standstill(standstill), .meas(meas),
    .motor_current_on_ff(cur_on), .brake_open_ff(brk_open), .brake_drive_ff(brk_drv),
    .op_enabled_ff(op_en), .readings_fresh_ff(fresh));
  od_master m (.core_clk(core_clk), .od_req(od_req), .od_rsp_ff(od_rsp_ff), .lost(lost));

  always #12.5 core_clk = ~core_clk;

  // ------------------------------------------------------------
  // checking helpers
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic cmp_val(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_val

  task automatic cmp_flag(string nm, logic e, logic g);
    cmp_val(nm, {31'h0, e}, {31'h0, g});
  endtask : cmp_flag

  // a lost answer means the port hung, so stop rather than cascade
  task automatic acc(logic wr, logic [15:0] idx, logic [7:0] sub, logic [31:0] wd);
    m.xfer(wr, idx, sub, wd, d, ab);
    // read the flag inside the master: the port copy may lag by a delta
    if (m.lost) begin
      fail_count++;
      $display("FAIL answer expected ack seen none");
      tally_and_finish();
    end
  endtask : acc

  function automatic logic sig(int w);
    case (w)
      0:       return cur_on;
      1:       return brk_open;
      2:       return op_en;
      default: return fresh;
    endcase
  endfunction : sig

  task automatic wait_on(int w, logic lvl, int bound, output int cnt);
    cnt = 0;
    while (sig(w) !== lvl && cnt < bound) begin
      @(posedge core_clk);
      #1;
      cnt++;
    end
    if (cnt == bound) begin
      fail_count++;
      $display("FAIL wait %0d expected %b seen timeout", w, lvl);
      tally_and_finish();
    end
  endtask : wait_on

  function automatic logic near(int v, int e, int tol);
    return v >= e && v <= e + tol;
  endfunction : near

  function automatic longint isqrt(longint v);
    longint r;
    longint t;
    r = 0;
    for (int k = 31; k >= 0; k--) begin
      t = r | (longint'(1) << k);
      if (t * t <= v)
        r = t;
    end
    return r;
  endfunction : isqrt

  function automatic logic duty_ok(logic [31:0] v);
    return v == 32'h0 || (v >= DUTY_MIN && v <= DUTY_MAX);
  endfunction : duty_ok

  // one capture, then every reading against its own arithmetic
  task automatic meas_case(logic cl, int a, int b, int f, int t);
    longint al;
    longint be;
    longint s;
    al = a;
    be = ((al + 2 * longint'(b)) * longint'(INV_SQRT3_Q16)) >>> 16;
    s = isqrt((al * al + be * be) / 2);
    last_tot = (cl && t < 0) ? 32'(-s) : 32'(s);
    @(posedge core_clk);
    meas <= '{1'b1, cl, 32'(a), 32'(b), 32'(f), 32'(t)};
    @(posedge core_clk);
    meas.valid <= 1'b0;
    #1;
    wait_on(3, 1'b1, 60, n);
    acc(1'b0, IDX_CURRENTS, SUB_FIELD, 32'h0);
    cmp_val("field", cl ? 32'(f) : 32'h0, d);
    acc(1'b0, IDX_CURRENTS, SUB_TORQUE, 32'h0);
    cmp_val("torque", cl ? 32'(t) : 32'h0, d);
    acc(1'b0, IDX_CURRENTS, SUB_ALPHA, 32'h0);
    cmp_val("alpha", 32'(a), d);
    acc(1'b0, IDX_CURRENTS, SUB_BETA, 32'h0);
    cmp_val("beta", 32'(be), d);
    acc(1'b0, IDX_CURRENTS, SUB_TOTAL, 32'h0);
    cmp_val("total", last_tot, d);
  endtask : meas_case

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    enable_req = 1'b0;
    standstill = 1'b0;
    meas = '0;
    fail_count = 0;
    checks = 0;
    void'($urandom(83));
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    acc(1'b0, IDX_CURRENTS, SUB_COUNT, 32'h0);
    cmp_val("count", {24'h0, CURRENT_ENTRY_COUNT}, d);
    for (int s = 1; s <= 5; s++) begin
      acc(1'b0, IDX_CURRENTS, 8'(s), 32'h0);
      cmp_val("reading_rst", READING_RST, d);
    end
    $display("test reset done");
    // corner cases first: negative torque in closed loop, then open loop
    for (int i = 0; i < 6; i++) begin
      meas_case(i == 0 ? 1'b1 : i == 1 ? 1'b0 : 1'($urandom_range(1, 0)),
                int'($urandom_range(40000, 0)) - 20000, int'($urandom_range(40000, 0)) - 20000,
                int'($urandom_range(9000, 0)) - 4500,
                i == 0 ? -1500 : int'($urandom_range(9000, 0)) - 4500);
    end
    $display("test currents done");
    for (int s = 0; s <= 5; s++) begin
      acc(1'b1, IDX_CURRENTS, 8'(s), $urandom());
      cmp_flag("ro_abort", 1'b1, ab);
    end
    acc(1'b0, IDX_CURRENTS, SUB_COUNT, 32'h0);
    cmp_val("count_kept", {24'h0, CURRENT_ENTRY_COUNT}, d);
    acc(1'b0, IDX_CURRENTS, SUB_TOTAL, 32'h0);
    cmp_val("total_kept", last_tot, d);
    $display("test read_only done");
    hi = 0;
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 32'h0 : (i == 1) ? 32'h1 : (i == 2) ? 32'h2 : (i == 3) ? 32'h64
        : (i == 4) ? 32'h65 : 32'($urandom_range(300, 0));
      n = duty_ok(d);
      // expectation taken before the access, which overwrites d with the answer
      if (n)
        hi = int'(d);
      acc(1'b1, IDX_BRAKE, SUB_PWM_DUTY, d);
      cmp_flag("duty_abort", !n, ab);
      acc(1'b0, IDX_BRAKE, SUB_PWM_DUTY, 32'h0);
      cmp_val("duty", 32'(hi), d);
    end
    $display("test duty done");
    for (int i = 0; i < 4; i++) begin
      dl[i] = $urandom_range(4, 1);
      acc(1'b1, IDX_BRAKE, 8'(SUB_CLOSE_DLY + i), 32'(dl[i]));
    end
    acc(1'b1, IDX_BRAKE, SUB_PWM_FREQ, 32'h000F_4240);  // 40-cycle period
    acc(1'b1, IDX_BRAKE, SUB_PWM_DUTY, 32'h0000_0032);
    @(posedge core_clk);
    enable_req <= 1'b1;
    #1;
    wait_on(0, 1'b1, 20, n);
    cmp_flag("on_first", 1'b1, n == 1);
    cmp_flag("brake_shut", 1'b0, brk_open);
    wait_on(1, 1'b1, 100, n);
    cmp_flag("open_dly", 1'b1, near(n, dl[2] * U, 1));
    wait_on(2, 1'b1, 100, n);
    cmp_flag("run_dly", 1'b1, near(n, dl[3] * U, 1));
    hi = 0;
    rises = 0;
    prv = brk_drv;
    // rising edges pin down the period, which the high count alone cannot
    repeat (400) begin
      @(posedge core_clk);
      #1;
      hi += int'(brk_drv);
      rises += int'(brk_drv && !prv);
      prv = brk_drv;
    end
    cmp_flag("pwm_half", 1'b1, near(hi, 192, 16));
    cmp_val("pwm_periods", 32'h0000_000A, 32'(rises));
    acc(1'b1, IDX_BRAKE, SUB_PWM_DUTY, 32'h0000_0064);
    repeat (3) @(posedge core_clk);
    hi = 0;
    repeat (40) begin
      @(posedge core_clk);
      #1;
      hi += int'(brk_drv);
    end
    cmp_val("pwm_full", 32'd40, 32'(hi));
    $display("test enable done");
    @(posedge core_clk);
    enable_req <= 1'b0;
    standstill <= 1'b1;
    #1;
    wait_on(2, 1'b0, 20, n);
    wait_on(1, 1'b0, 100, hi);
    cmp_flag("close_dly", 1'b1, near(n + hi, dl[0] * U, 2));
    cmp_flag("cur_held", 1'b1, cur_on);
    wait_on(0, 1'b0, 100, n);
    cmp_flag("off_dly", 1'b1, near(n, dl[1] * U, 1));
    cmp_flag("drive_idle", 1'b0, brk_drv);
    $display("test stop done");
    tally_and_finish();
  end
endmodule : brake_current_unit_tb
